// ==== rtl/divcfg_pkg.sv ====
package divcfg_pkg;
   // ****************************************
   // word layout
   // ****************************************
   localparam int WORD_W      = 32;             // shifted word width
   localparam int SEL_W       = 3;              // latch index width
   localparam int NUM_LATCH   = 8;              // number of latches
   localparam int INT_W       = 12;             // integer divide width
   localparam int FRAC_W      = 25;             // fraction width
   localparam int FRAC_LO_W   = 13;             // fraction lsb part
   localparam int FRAC_HI_W   = 12;             // fraction msb part
   localparam int RCNT_W      = 5;              // reference counter width
   localparam int OBS_W       = 4;              // observation select width
   localparam int CUR_W       = 4;              // pump current width
   // latch zero fields
   localparam int L0_FRAC_HI_LSB = 3;
   localparam int L0_INT_LSB     = 15;
   localparam int L0_OBS_LSB     = 27;
   // latch one fields
   localparam int L1_FRAC_LO_LSB = 15;
   // latch two fields
   localparam int L2_RCNT_LSB    = 15;
   localparam int L2_DBL_BIT     = 20;
   localparam int L2_HALF_BIT    = 21;
   localparam int L2_CUR_LSB     = 24;
   // latch indices
   localparam logic [2:0] LATCH_ZERO = 3'h0;
   localparam logic [2:0] LATCH_ONE  = 3'h1;
   localparam logic [2:0] LATCH_TWO  = 3'h2;
   // integer divide limits
   localparam logic [11:0] INT_MIN   = 12'h017;  // 23
   localparam logic [11:0] INT_MAX   = 12'hfff;  // 4095
   // observation select codes
   localparam logic [3:0] OBS_LOW    = 4'h0;
   localparam logic [3:0] OBS_HIGH   = 4'h1;
   localparam logic [3:0] OBS_REFDIV = 4'h2;
   localparam logic [3:0] OBS_FBDIV  = 4'h3;
   localparam logic [3:0] OBS_READY  = 4'h4;
   // host timing: serial clock half period in system clocks
   localparam int HALF_NS     = 20;
   localparam int CLK_NS      = 10;
   localparam int HALF_CYC    = (HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int BITCNT_W    = 6;
endpackage

// ==== rtl/divcfg_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface divcfg_if;
   logic sclk;          // serial clock
   logic sdata;         // serial data
   logic load_strobe;   // load strobe
   logic chip_en;       // chip enable
   modport host   (output sclk, output sdata, output load_strobe, output chip_en);
   modport device (input  sclk, input  sdata, input  load_strobe, input  chip_en);
endinterface
`default_nettype wire

// ==== rtl/divcfg_device.sv ====
// Function
// (R01) shift one bit per clock rise, msb first
// (R02) strobe rise copies word into one latch
// (R03) low three bits pick the latch
// (R04) buffered fields go active on latch zero write
// (R05) fraction lsbs latch one, msbs latch zero
// (R06) latch one before zero; change after zero
// (R07) integer divide 12 bits, 23 to 4095
// (R08) division is integer plus fraction over 2^25
// (R09) reference counter 5 bits, ratio 1..32
// (R10) reference rate uses doubler and halver
// (R11) four-bit field picks observation output
// (R12) chip enable low powers down, pump off
// (R13) latches change only on strobe rise
`timescale 1ns/1ps
`default_nettype none
module divcfg_device
   import divcfg_pkg::*;
(
   // clock and reset
   input  wire logic                         clock_i,
   input  wire logic                         srst_i,
   // serial link
   divcfg_if.device                          link,
   // configuration outputs
   output logic [divcfg_pkg::INT_W-1:0]      int_div_o,
   output logic [divcfg_pkg::FRAC_W-1:0]     frac_o,
   output logic [divcfg_pkg::RCNT_W-1:0]     ref_count_o,
   output logic [5:0]                        ref_ratio_o,
   output logic                              doubler_o,
   output logic                              reference_halver_bit_o,
   output logic [divcfg_pkg::CUR_W-1:0]      pump_current_o,
   output logic [divcfg_pkg::OBS_W-1:0]      obs_select_o,
   output logic                              int_valid_o,
   output logic                              freq_update_o,
   output logic                              powered_down_o,
   output logic                              pump_enable_o,
   output logic                              observation_output_pin_o,
   // monitoring of latches
   output logic [divcfg_pkg::WORD_W-1:0]     latch_o [divcfg_pkg::NUM_LATCH],
   // internal points for the observation mux
   input  wire logic                         ref_div_clk_i,
   input  wire logic                         fb_div_clk_i
);
   import divcfg_pkg::*;

   // ****************************************
   // elaboration checks
   // ****************************************
   // the latch index must reach every latch and no more
   if ((1 << SEL_W) != NUM_LATCH)
   begin : g_bad_sel
      $error("latch index width does not fit the latch count");
   end
   // the two fraction parts must make up the whole numerator
   if (FRAC_LO_W + FRAC_HI_W != FRAC_W)
   begin : g_bad_frac
      $error("fraction parts do not add up to the numerator");
   end
   // the observation and pump current fields must sit inside one shifted word
   if ((L0_OBS_LSB + OBS_W > WORD_W) || (L2_CUR_LSB + CUR_W > WORD_W))
   begin : g_bad_field
      $error("latch field runs past the end of the word");
   end

   // ****************************************
   // state
   // ****************************************
   // the whole block state is one record, so one register process
   // holds it and a reset clears all of it on the same edge
   typedef struct packed {
      // previous link levels, for rising edge detection
      logic                      sclk_prev;   // serial clock last cycle
      logic                      strobe_prev; // strobe last cycle
      // serial input and the eight raw latches
      logic [WORD_W-1:0]         shift;       // input shift register
      logic [NUM_LATCH-1:0][WORD_W-1:0] latch; // eight latches
      // double-buffered values in use, moved only on a latch zero load
      logic [FRAC_LO_W-1:0]      act_frac_lo; // active fraction lsbs
      logic [RCNT_W-1:0]         act_rcnt;    // active reference code
      logic                      act_dbl;     // active doubler
      logic                      act_half;    // active halver
      logic [CUR_W-1:0]          act_cur;     // active pump current
      // frequency change marker
      logic                      upd;         // one-cycle change pulse
   } state_t;

   // register and its next value
   state_t s_q;   // registered state
   state_t s_d;   // next state

   // ****************************************
   // latch index
   // ****************************************
   // the index sits in the lowest bits of the finished word
   // three bits reach all eight latches, so no index is refused
   logic [SEL_W-1:0] sel;   // latch index from shifted word
   assign sel = s_q.shift[SEL_W-1:0]; // R03

   // ****************************************
   // next state
   // ****************************************
   // edge detect, shift and load in one pass; the link runs slow
   // against clock_i, so each link edge is seen on exactly one clock
   // limitation: a strobe rise on the same clock as a serial clock
   // rise loads the word before that bit has landed
   always_comb
   begin
      // hold everything by default, pulses low
      s_d             = s_q;
      s_d.upd         = 1'b0;
      s_d.sclk_prev   = link.sclk;
      s_d.strobe_prev = link.load_strobe;
      // shift on serial clock rise, new bit enters lsb so msb leads
      if (link.sclk && !s_q.sclk_prev)
      begin
         s_d.shift = {s_q.shift[WORD_W-2:0], link.sdata}; // R01
      end
      // only a strobe rise touches latches; edge timing set by the host
      if (link.load_strobe && !s_q.strobe_prev) // R13
      begin
         // the whole word goes in, index bits included
         s_d.latch[sel] = s_q.shift; // R02
         // writes to other latches leave the active set alone
         if (sel == LATCH_ZERO)
         begin
            // buffered copies follow latch one and two only here
            s_d.act_frac_lo = s_q.latch[LATCH_ONE][L1_FRAC_LO_LSB +: FRAC_LO_W]; // R04
            s_d.act_rcnt    = s_q.latch[LATCH_TWO][L2_RCNT_LSB +: RCNT_W];      // R04
            s_d.act_dbl     = s_q.latch[LATCH_TWO][L2_DBL_BIT];                 // R04
            s_d.act_half    = s_q.latch[LATCH_TWO][L2_HALF_BIT];                // R04
            s_d.act_cur     = s_q.latch[LATCH_TWO][L2_CUR_LSB +: CUR_W];        // R04
            s_d.upd         = 1'b1; // R06
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   // one register for the whole record, cleared by the synchronous reset
   // a reset in mid-word drops the partial word; the host must resend
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // all data outputs but power-down, pump enable and the observation pin are decoded from registered state
   // integer divide straight from latch zero
   assign int_div_o   = s_q.latch[LATCH_ZERO][L0_INT_LSB +: INT_W]; // R07
   // fraction numerator 0..2^25-1 over fixed modulus
   assign frac_o      = {s_q.latch[LATCH_ZERO][L0_FRAC_HI_LSB +: FRAC_HI_W],
                         s_q.act_frac_lo}; // R05 R08
   // active reference code as stored
   assign ref_count_o = s_q.act_rcnt;
   // code zero means a ratio of 32
   assign ref_ratio_o = (s_q.act_rcnt == '0) ? 6'(1 << RCNT_W) : {1'b0, s_q.act_rcnt}; // R09
   // rate is (1 + doubler) over (ratio times (1 + halver))
   assign doubler_o   = s_q.act_dbl;  // R10
   assign reference_halver_bit_o = s_q.act_half; // R10
   // pump current is a buffered setting as well
   assign pump_current_o = s_q.act_cur; // R04
   // observation select is not buffered and acts at once
   assign obs_select_o   = s_q.latch[LATCH_ZERO][L0_OBS_LSB +: OBS_W]; // R11
   // out-of-range integer flagged, not corrected
   assign int_valid_o    = (int_div_o >= INT_MIN) && (int_div_o <= INT_MAX); // R07
   // change pulse is high for one clock, from the same edge as the latch zero load
   assign freq_update_o  = s_q.upd; // R06
   // power-down is a plain level taken from the enable line
   assign powered_down_o = !link.chip_en; // R12
   assign pump_enable_o  = link.chip_en;  // R12

   // raw latch contents for monitoring, one lane per latch
   genvar g;
   for (g = 0; g < NUM_LATCH; g++)
   begin : g_mon
      assign latch_o[g] = s_q.latch[g];
   end

   // ****************************************
   // observation output
   // ****************************************
   // combinational, so the divided clocks pass without a cycle of delay
   // powering down does not silence the pin; only the pump is released
   // only the low codes are decoded; the rest are spare
   always_comb
   begin
      case (obs_select_o) // R11
         OBS_LOW:    observation_output_pin_o = 1'b0;
         OBS_HIGH:   observation_output_pin_o = 1'b1;
         OBS_REFDIV: observation_output_pin_o = ref_div_clk_i;
         OBS_FBDIV:  observation_output_pin_o = fb_div_clk_i;
         OBS_READY:  observation_output_pin_o = int_valid_o;
         default:    observation_output_pin_o = 1'b0; // spare codes read low
      endcase
   end
endmodule
`default_nettype wire

// ==== rtl/divcfg_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module divcfg_host
   import divcfg_pkg::*;
(
   // clock and reset
   input  wire logic                      clock_i,
   input  wire logic                      srst_i,
   // user command
   input  wire logic                      send_i,
   input  wire logic [divcfg_pkg::WORD_W-1:0] word_i,
   input  wire logic                      chip_en_i,
   output logic                           busy_o,
   output logic                           done_o,
   output logic                           refused_o,
   // serial link
   divcfg_if.host                         link
);
   import divcfg_pkg::*;

   // the half period timer is four bits and the bit counter six
   if ((HALF_CYC < 1) || (HALF_CYC > 16) || (WORD_W >= (1 << BITCNT_W)))
   begin : g_bad_timing
      $error("host timer or bit counter too narrow");
   end

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LOW   = 2'b01,
      ST_HIGH  = 2'b10,
      ST_LOAD  = 2'b11
   } phase_t;

   typedef struct packed {
      phase_t              ph;
      logic [WORD_W-1:0]   sh;    // word, msb out first
      logic [BITCNT_W-1:0] bits;  // bits left
      logic [3:0]          tick;  // half period timer
      logic                sclk;
      logic                sdata;
      logic                strobe;
      logic                done;
      logic                refused;
      logic                ce;
   } hstate_t;

   hstate_t h_q;   // registered
   hstate_t h_d;   // next
   logic    half;  // half period elapsed
   logic    int_ok;

   assign half   = (h_q.tick == 4'(HALF_CYC - 1));
   // integer field only checked on latch zero words
   // every 5-bit reference code maps to a legal ratio, so none is refused
   assign int_ok = (word_i[SEL_W-1:0] != LATCH_ZERO) ||
                   (word_i[L0_INT_LSB +: INT_W] >= INT_MIN); // R07 R09

   // ****************************************
   // sequencer
   // ****************************************
   always_comb
   begin
      h_d         = h_q;
      h_d.done    = 1'b0;
      h_d.refused = 1'b0;
      h_d.ce      = chip_en_i;
      h_d.tick    = half ? 4'h0 : h_q.tick + 4'h1;
      case (h_q.ph)
         ST_IDLE:
         begin
            h_d.tick = 4'h0;
            if (send_i && int_ok)
            begin
               // caller supplies the latch index in the low bits
               h_d.sh    = word_i; // R03
               h_d.bits  = 6'(WORD_W);
               h_d.ph    = ST_LOW;
               h_d.sdata = word_i[WORD_W-1];
            end
            else if (send_i)
            begin
               h_d.refused = 1'b1;
            end
         end
         ST_LOW:
         if (half)
         begin
            h_d.sclk = 1'b1; // R01
            h_d.ph   = ST_HIGH;
         end
         ST_HIGH:
         if (half)
         begin
            h_d.sclk = 1'b0;
            h_d.sh   = {h_q.sh[WORD_W-2:0], 1'b0};
            h_d.bits = h_q.bits - 6'h1;
            h_d.sdata = h_q.sh[WORD_W-2]; // R01
            h_d.ph   = (h_q.bits == 6'h1) ? ST_LOAD : ST_LOW;
         end
         ST_LOAD:
         if (half)
         begin
            // strobe high for a half period, then back to idle
            h_d.strobe = !h_q.strobe;
            if (h_q.strobe)
            begin
               h_d.ph   = ST_IDLE;
               // caller waits for this before the next word, latch zero last
               h_d.done = 1'b1; // R06
            end
         end
         default: h_d.ph = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         h_q <= '0;
      end
      else
      begin
         h_q <= h_d;
      end
   end

   assign busy_o           = (h_q.ph != ST_IDLE);
   assign done_o           = h_q.done;
   assign refused_o        = h_q.refused;
   assign link.sclk        = h_q.sclk;
   assign link.sdata       = h_q.sdata;
   assign link.load_strobe = h_q.strobe;
   assign link.chip_en     = h_q.ce;
endmodule
`default_nettype wire

// ==== bench/divcfg_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module divcfg_sva
(
   // clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // link lines
   input wire logic sclk,
   input wire logic sdata,
   input wire logic load_strobe,
   input wire logic chip_en
);
   // ****************************************
   // bit counter
   // ****************************************
   logic [5:0] bits_q; // sclk rises in word
   logic [5:0] bits_d;
   logic       sclk_q; // last sclk level
   // clear while strobe high so each word counts alone
   always_comb
   begin
      bits_d = bits_q;
      if (load_strobe)
         bits_d = 6'h00;
      else if (sclk && !sclk_q)
         bits_d = bits_q + 6'h01;
   end
   // register helper state
   always_ff @(posedge clock_i)
   begin
      bits_q <= srst_i ? 6'h00 : bits_d;
      sclk_q <= srst_i ? 1'b0 : sclk;
   end
   // ****************************************
   // wire checks
   // ****************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   a_strobe_sclk_low: assert property (load_strobe |-> !sclk)
      else $error("strobe with sclk high");
   a_word_length: assert property ($rose(load_strobe) |-> bits_q == 6'h20)
      else $error("word not 32 bits");
   a_count_bound: assert property (bits_q <= 6'h20)
      else $error("more than 32 bits");
   a_sclk_high_two: assert property ($rose(sclk) |=> sclk ##1 !sclk)
      else $error("sclk high phase wrong");
   a_sclk_low_two: assert property ($fell(sclk) |=> !sclk)
      else $error("sclk low phase short");
   a_data_stable: assert property (sclk |-> $stable(sdata))
      else $error("sdata moved while sclk high");
   a_strobe_two: assert property ($rose(load_strobe) |=> load_strobe ##1 !load_strobe)
      else $error("strobe width wrong");
   a_idle_after_load: assert property ($fell(load_strobe) |-> !sclk ##1 !sclk)
      else $error("sclk right after strobe");
   cover property ($rose(load_strobe));
   cover property ($fell(chip_en));
   cover property ($rose(sclk) && sdata);
endmodule
`default_nettype wire

// ==== bench/test_serial_divider_config_loader.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_serial_divider_config_loader;
   import divcfg_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic clock_i = 1'b0;
   logic srst_i = 1'b1;
   logic send_i = 1'b0;
   logic [31:0] word_i = 32'h0;
   logic chip_en_i = 1'b1;
   logic ref_div_clk_i = 1'b0;
   logic fb_div_clk_i = 1'b0;
   logic busy_o, done_o, refused_o, doubler_o, reference_halver_bit_o;
   logic int_valid_o, freq_update_o, powered_down_o, pump_enable_o;
   logic observation_output_pin_o;
   logic [11:0] int_div_o;
   logic [24:0] frac_o;
   logic [4:0] ref_count_o;
   logic [5:0] ref_ratio_o;
   logic [3:0] pump_current_o, obs_select_o;
   logic [31:0] latch_o [8];
   int fails = 0;
   int check_count = 0;
   logic upd, refd; // pulses seen in a send
   divcfg_if divcfg_if_i ();
   divcfg_host divcfg_host_i (.clock_i(clock_i), .srst_i(srst_i), .send_i(send_i),
      .word_i(word_i), .chip_en_i(chip_en_i), .busy_o(busy_o), .done_o(done_o),
      .refused_o(refused_o), .link(divcfg_if_i));
   divcfg_device divcfg_device_i (.clock_i(clock_i), .srst_i(srst_i), .link(divcfg_if_i),
      .int_div_o(int_div_o), .frac_o(frac_o), .ref_count_o(ref_count_o),
      .ref_ratio_o(ref_ratio_o), .doubler_o(doubler_o),
      .reference_halver_bit_o(reference_halver_bit_o), .pump_current_o(pump_current_o),
      .obs_select_o(obs_select_o), .int_valid_o(int_valid_o),
      .freq_update_o(freq_update_o), .powered_down_o(powered_down_o),
      .pump_enable_o(pump_enable_o), .observation_output_pin_o(observation_output_pin_o),
      .latch_o(latch_o), .ref_div_clk_i(ref_div_clk_i), .fb_div_clk_i(fb_div_clk_i));
   divcfg_sva divcfg_sva_i (.clock_i(clock_i), .srst_i(srst_i), .sclk(divcfg_if_i.sclk),
      .sdata(divcfg_if_i.sdata), .load_strobe(divcfg_if_i.load_strobe),
      .chip_en(divcfg_if_i.chip_en));
   // ****************************************
   // helpers
   // ****************************************
   task automatic final_report;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check_word(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic check_flag(string n, logic e, logic g);
      check_word(n, 32'(e), 32'(g));
   endtask
   // one cycle, catching short pulses
   task automatic tick;
      @(negedge clock_i);
      upd = upd | (freq_update_o === 1'b1);
      refd = refd | (refused_o === 1'b1);
   endtask
   // send one word, bounded wait for done or refusal
   task automatic send(logic [31:0] w);
      int n;
      logic take;
      n = 0;
      take = (w[SEL_W-1:0] != LATCH_ZERO) || (w[L0_INT_LSB +: INT_W] >= INT_MIN);
      word_i = w;
      send_i = 1'b1;
      upd = 1'b0;
      refd = 1'b0;
      tick();
      send_i = 1'b0;
      check_flag("busy", take, busy_o);
      while (done_o !== 1'b1 && !refd && n < 400)
      begin
         tick();
         n++;
      end
      if (n == 400)
      begin
         fails++;
         final_report();
      end
      repeat (3) tick();
      check_flag("idle", 1'b0, busy_o);
   endtask
   function automatic logic [31:0] w0(logic [3:0] o, logic [11:0] i, logic [11:0] f);
      return {1'b0, o, i, f, 3'h0};
   endfunction
   function automatic logic [31:0] w2(logic [3:0] c, logic t, logic d, logic [4:0] r);
      return {4'h0, c, 2'h0, t, d, r, 12'h000, 3'h2};
   endfunction
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_latches;
      logic [31:0] w;
      for (int k = 1; k < 8; k++)
      begin
         w = {24'hc3a5f0, 5'(k), 3'(k)};
         send(w);
         check_word("latch", w, latch_o[k]);
         check_word("latch0", 32'h0, latch_o[0]);
      end
      check_word("frac", 32'h0, 32'(frac_o));
      check_word("rcount", 32'h0, 32'(ref_count_o));
      $display("t_latches done");
   endtask
   task automatic t_fraction;
      send({4'h0, 13'h1abc, 12'h000, 3'h1});
      check_word("frac", 32'h0, 32'(frac_o));
      check_flag("update", 1'b0, upd);
      send(w0(4'h0, 12'h017, 12'h9e5));
      check_word("frac", 32'({12'h9e5, 13'h1abc}), 32'(frac_o));
      check_word("int", 32'h017, 32'(int_div_o));
      check_flag("update", 1'b1, upd);
      $display("t_fraction done");
   endtask
   task automatic t_refdiv;
      send(w2(4'h9, 1'b1, 1'b1, 5'h00));
      send(w0(4'h0, 12'hfff, 12'h000));
      check_word("ratio", 32'h20, 32'(ref_ratio_o));
      check_word("ctrl", 32'h27, 32'({pump_current_o, doubler_o, reference_halver_bit_o}));
      send(w2(4'h3, 1'b0, 1'b1, 5'h01));
      check_word("ctrl", 32'h27, 32'({pump_current_o, doubler_o, reference_halver_bit_o}));
      send(w0(4'h0, 12'hfff, 12'h000));
      check_word("ratio", 32'h01, 32'(ref_ratio_o));
      check_word("rcount", 32'h01, 32'(ref_count_o));
      check_word("ctrl", 32'h0e, 32'({pump_current_o, doubler_o, reference_halver_bit_o}));
      check_word("int", 32'hfff, 32'(int_div_o));
      $display("t_refdiv done");
   endtask
   task automatic t_refused;
      send(w0(4'h0, 12'h016, 12'h001));
      check_flag("refused", 1'b1, refd);
      check_word("int", 32'hfff, 32'(int_div_o));
      $display("t_refused done");
   endtask
   // pin follows select: low, high, ref clock, fb clock, valid, spare
   task automatic t_obs;
      logic [5:0] e1;
      logic [5:0] e2;
      e1 = 6'b010110;
      e2 = 6'b011010;
      for (int c = 0; c < 6; c++)
      begin
         send(w0(4'(c), 12'h100, 12'h000));
         check_word("obs", 32'(c), 32'(obs_select_o));
         ref_div_clk_i = 1'b1;
         fb_div_clk_i = 1'b0;
         tick();
         check_flag("pin", e1[c], observation_output_pin_o);
         ref_div_clk_i = 1'b0;
         fb_div_clk_i = 1'b1;
         tick();
         check_flag("pin", e2[c], observation_output_pin_o);
      end
      $display("t_obs done");
   endtask
   task automatic t_power;
      chip_en_i = 1'b0;
      repeat (2) tick();
      check_flag("down", 1'b1, powered_down_o);
      check_flag("pump", 1'b0, pump_enable_o);
      chip_en_i = 1'b1;
      repeat (2) tick();
      check_flag("down", 1'b0, powered_down_o);
      check_flag("pump", 1'b1, pump_enable_o);
      $display("t_power done");
   endtask
   // reset in mid-run clears latches and the active set
   task automatic t_reset;
      srst_i = 1'b1;
      repeat (2) tick();
      srst_i = 1'b0;
      tick();
      check_word("latch0", 32'h0, latch_o[0]);
      check_word("int", 32'h0, 32'(int_div_o));
      check_word("ratio", 32'h20, 32'(ref_ratio_o));
      check_flag("valid", 1'b0, int_valid_o);
      send(w0(4'h4, 12'h017, 12'h000));
      check_flag("valid", 1'b1, int_valid_o);
      $display("t_reset done");
   endtask
   // 100 MHz clock
   initial
   begin
      forever #5 clock_i = ~clock_i;
   end
   initial
   begin
      repeat (16) @(posedge clock_i);
      @(negedge clock_i);
      srst_i = 1'b0;
      t_latches();
      t_fraction();
      t_refdiv();
      t_refused();
      t_obs();
      t_power();
      t_reset();
      final_report();
   end
endmodule
`default_nettype wire
